// file: rtl/timer_defs.vh
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// register indices; byte address is four times the index
`define IDX_COUNT 12'h001
`define IDX_OPTION 12'h081
`define IDX_INTCTL 12'h00B
`define IDX_STATUS 12'h040
`define IDX_CLEAR 12'h041
`define IDX_ENABLE 12'h042

// option register fields
`define OPT_SRC_BIT 5
`define OPT_EDGE_BIT 4
`define OPT_ASSIGN_BIT 3
`define OPT_RATIO_MSB 2
`define OPT_RATIO_LSB 0
`define OPTION_RESET 8'hFF

// interrupt control register fields
`define INT_ENABLE_BIT 5
`define INT_FLAG_BIT 2
`define INTCTL_RESET 8'h00

// count register reset value
`define COUNT_RESET 8'h00

// timing: oscillator periods per instruction cycle, write inhibit length
`define TOSC_PER_INSTR 4
`define WRITE_INHIBIT_CYCLES 2

`endif

// file: rtl/prescaler_unit.v
`timescale 1ns/1ps
`default_nettype none

// shared 8-bit divider; output pulses once per 2^(ratio+1) source pulses
module prescaler_unit #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire reset_n,
    input wire clear,
    input wire src_pulse,
    input wire [2:0] ratio,
    output reg out_pulse
);

    reg [WIDTH-1:0] count;

    // mask of low bits that must all be ones before the divided pulse
    function [WIDTH-1:0] ratio_mask;
        input [2:0] sel;
        begin
            ratio_mask = ({WIDTH{1'b1}} >> (WIDTH - 1 - sel));
        end
    endfunction

    // counter value is internal only, never visible to software
    always @(posedge clk) begin
        if (!reset_n) begin
            count <= {WIDTH{1'b0}};
            out_pulse <= 1'b0;
        end else if (clear) begin
            count <= {WIDTH{1'b0}};
            out_pulse <= 1'b0;
        end else begin
            out_pulse <= 1'b0;
            if (src_pulse) begin
                count <= count + 1'b1;
                if ((count & ratio_mask(ratio)) == ratio_mask(ratio)) begin
                    out_pulse <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: rtl/eight_bit_timer_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"

module eight_bit_timer_counter #(
    parameter PRESCALE_WIDTH = 8
) (
    input wire clk,
    input wire reset_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire external_count_input,
    input wire sleep_mode,
    input wire watchdog_tick,
    input wire watchdog_clear,
    output reg watchdog_scaled_tick,
    output reg irq
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    reg [7:0] count_register;
    reg [7:0] option_reg;
    reg overflow_int_enable;
    reg overflow_flag;
    reg [1:0] phase;
    reg instr_en;
    reg [1:0] inhibit_cnt;
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    reg dp_valid;
    reg dp_write;
    reg [11:0] dp_index;

    wire count_source_select = option_reg[`OPT_SRC_BIT];
    wire source_edge_select = option_reg[`OPT_EDGE_BIT];
    wire prescaler_assign = option_reg[`OPT_ASSIGN_BIT];
    wire [2:0] prescale_ratio_select = option_reg[`OPT_RATIO_MSB:`OPT_RATIO_LSB];

    // sized copies of header constants for narrow targets
    localparam [1:0] INHIBIT_LOAD = `WRITE_INHIBIT_CYCLES;
    localparam [7:0] INTCTL_INIT = `INTCTL_RESET;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    // register index from a byte address
    function [11:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[13:2];
        end
    endfunction

    wire addr_phase = hsel && hready && htrans[1];
    wire wr_now = dp_valid && dp_write;
    wire wr_count = wr_now && (dp_index == `IDX_COUNT);
    wire wr_option = wr_now && (dp_index == `IDX_OPTION);
    wire wr_intctl = wr_now && (dp_index == `IDX_INTCTL);
    wire wr_clear = wr_now && (dp_index == `IDX_CLEAR);
    wire wr_enable = wr_now && (dp_index == `IDX_ENABLE);

    // capture address phase for the following data phase
    always @(posedge clk) begin
        if (!reset_n) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_index <= 12'h000;
        end else if (hready) begin
            dp_valid <= addr_phase;
            dp_write <= hwrite;
            dp_index <= word_index(haddr);
        end
    end

    // zero wait states, always OKAY
    always @(posedge clk) begin
        if (!reset_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered at the address phase; unmapped reads zero

    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (word_index(haddr))
            `IDX_COUNT: next_rdata = count_register;
            `IDX_OPTION: next_rdata = option_reg;
            `IDX_INTCTL: begin
                next_rdata[`INT_ENABLE_BIT] = overflow_int_enable;
                next_rdata[`INT_FLAG_BIT] = overflow_flag;
            end
            `IDX_STATUS: next_rdata = {7'h00, overflow_flag};
            `IDX_ENABLE: next_rdata = {7'h00, overflow_int_enable};
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= {24'h000000, next_rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option register

    always @(posedge clk) begin
        if (!reset_n) begin
            option_reg <= `OPTION_RESET;
        end else if (wr_option) begin
            option_reg <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction cycle enable: one pulse every four oscillator periods

    always @(posedge clk) begin
        if (!reset_n) begin
            phase <= 2'b00;
            instr_en <= 1'b0;
        end else begin
            phase <= phase + 2'b01;
            instr_en <= (phase == (`TOSC_PER_INSTR - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external input: three stages, edge taken where stages two and three differ

    always @(posedge clk) begin
        if (!reset_n) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= external_count_input;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    wire ext_rise = ext_s2 && !ext_s3;
    wire ext_fall = !ext_s2 && ext_s3;
    wire ext_edge = source_edge_select ? ext_fall : ext_rise;

    ////////////////////////////////////////////////////////////////////////
    // count source and shared prescaler

    // selected raw source; the timer counts nothing during sleep
    wire raw_src = sleep_mode ? 1'b0 : (count_source_select ? ext_edge : instr_en);
    wire pre_clear = prescaler_assign ? watchdog_clear : wr_count;
    wire pre_src = prescaler_assign ? watchdog_tick : raw_src;
    wire pre_out;

    prescaler_unit #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_prescaler (
        .clk(clk),
        .reset_n(reset_n),
        .clear(pre_clear),
        .src_pulse(pre_src),
        .ratio(prescale_ratio_select),
        .out_pulse(pre_out)
    );

    // counter sees the prescaler output only while it owns it
    wire pre_for_counter = pre_out && !sleep_mode;
    wire count_tick = prescaler_assign ? raw_src : pre_for_counter;

    // watchdog gets the divided tick while it owns the prescaler
    always @(posedge clk) begin
        if (!reset_n) begin
            watchdog_scaled_tick <= 1'b0;
        end else begin
            watchdog_scaled_tick <= prescaler_assign ? pre_out : watchdog_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write inhibit: two instruction cycles after a count write

    always @(posedge clk) begin
        if (!reset_n) begin
            inhibit_cnt <= 2'b00;
        end else if (wr_count) begin
            inhibit_cnt <= INHIBIT_LOAD;
        end else if (instr_en && inhibit_cnt != 2'b00) begin
            inhibit_cnt <= inhibit_cnt - 2'b01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count register

    wire do_inc = count_tick && (inhibit_cnt == 2'b00) && !wr_count;
    wire overflow_event = do_inc && (count_register == 8'hFF);

    always @(posedge clk) begin
        if (!reset_n) begin
            count_register <= `COUNT_RESET;
        end else if (wr_count) begin
            count_register <= hwdata[7:0];
        end else if (do_inc) begin
            count_register <= count_register + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flag and enable; a set in the clearing cycle wins

    wire flag_clear = (wr_intctl && !hwdata[`INT_FLAG_BIT]) || (wr_clear && hwdata[0]);

    always @(posedge clk) begin
        if (!reset_n) begin
            overflow_flag <= INTCTL_INIT[`INT_FLAG_BIT];
        end else if (overflow_event) begin
            overflow_flag <= 1'b1;
        end else if (flag_clear) begin
            overflow_flag <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            overflow_int_enable <= INTCTL_INIT[`INT_ENABLE_BIT];
        end else if (wr_intctl) begin
            overflow_int_enable <= hwdata[`INT_ENABLE_BIT];
        end else if (wr_enable) begin
            overflow_int_enable <= hwdata[0];
        end
    end

    // level interrupt while flag and enable are both set
    always @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= overflow_flag && overflow_int_enable;
        end
    end

endmodule

`default_nettype wire

// file: rtl/dummy_unused_marker.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/eight_bit_timer_counter_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"
module timer_chk (
    input wire clk,
    input wire reset_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire irq
);
    wire take = hsel && hready && htrans[1];
    wire [11:0] idx = haddr[13:2];
    reg ph_wr;
    reg [11:0] ph_idx;
    reg en;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // shadow of the overflow interrupt enable, fed by bus writes
    always @(posedge clk) begin
        if (!reset_n) begin
            ph_wr <= 1'b0;
            ph_idx <= 12'h000;
            en <= 1'b0;
        end else begin
            ph_wr <= take && hwrite;
            ph_idx <= idx;
            if (ph_wr && ph_idx == `IDX_INTCTL)
                en <= hwdata[`INT_ENABLE_BIT];
            if (ph_wr && ph_idx == `IDX_ENABLE)
                en <= hwdata[0];
        end
    end
    ////////////////////////////////////////////////////////////////
    // read request to one register, and a flag clear write
    sequence rd_of(logic [11:0] i);
        take && !hwrite && idx == i;
    endsequence
    sequence clr_wr;
        take && hwrite && idx == `IDX_CLEAR ##1 hwdata[0];
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave answered with an error");
    a_ready_up: assert property ($past(reset_n) |-> hreadyout)
        else $error("ready low outside reset");
    a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_clear_reads_zero: assert property (rd_of(`IDX_CLEAR) |=> hrdata == 32'h0)
        else $error("clear register read not zero");
    a_status_width: assert property (rd_of(`IDX_STATUS) |=> hrdata[31:1] == 31'h0)
        else $error("status read has stray bits");
    a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_irq_gated: assert property (irq |-> $past(en))
        else $error("interrupt while disabled");
    a_irq_cleared: assert property (clr_wr |-> ##2 !irq)
        else $error("interrupt stayed after flag clear");
endmodule
bind eight_bit_timer_counter timer_chk chk (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire

// file: test/test_eight_bit_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module test_eight_bit_timer_counter;
    localparam logic [31:0] CNT = `IDX_COUNT * 4;
    localparam logic [31:0] OPT = `IDX_OPTION * 4;
    localparam logic [31:0] ICT = `IDX_INTCTL * 4;
    localparam logic [31:0] STS = `IDX_STATUS * 4;
    localparam logic [31:0] CLR = `IDX_CLEAR * 4;
    localparam logic [31:0] ENA = `IDX_ENABLE * 4;
    logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, pin = 0, sleep = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, v;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq;
    int err_count = 0, n_tests = 0;
    logic wd_tick = 0, wd_clr = 0;
    wire wd_out;
    int wd_seen = 0;
    eight_bit_timer_counter dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_count_input(pin),
        .sleep_mode(sleep), .watchdog_tick(wd_tick), .watchdog_clear(wd_clr),
        .watchdog_scaled_tick(wd_out), .irq(irq));
    // count divided watchdog pulses
    always @(posedge clk) if (wd_out) wd_seen <= wd_seen + 1;
    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial forever #12.5 clk = ~clk;
    initial begin
        #500000;
        err_count++;
        results();
    end
    // one bus transfer; read data lands in rd
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // external pin edge, checked early and late against the selected edge
    task automatic edge_case(input logic [31:0] opt, input logic [31:0] e1);
        bus(1'h1, OPT, opt);
        bus(1'h1, CNT, 32'h0);
        cyc(12);
        pin <= 1'b1;
        cyc(2);
        bus(1'h0, CNT, 32'h0);
        `CHK(rd, 32'h0)
        cyc(3);
        bus(1'h0, CNT, 32'h0);
        `CHK(rd, e1)
        pin <= 1'b0;
        cyc(7);
        bus(1'h0, CNT, 32'h0);
        `CHK(rd, 32'h1)
    endtask
    // prescaler on the watchdog: divide by two, then divide by four with a clear mid-count
    task automatic wd_case;
        bus(1'h1, OPT, 32'h08);
        wd_clr <= 1'b1;
        cyc(1);
        wd_clr <= 1'b0;
        v = wd_seen;
        wd_tick <= 1'b1;
        cyc(8);
        wd_tick <= 1'b0;
        cyc(3);
        `CHK(wd_seen - v, 32'h4)
        bus(1'h1, OPT, 32'h09);
        wd_clr <= 1'b1;
        cyc(1);
        wd_clr <= 1'b0;
        v = wd_seen;
        wd_tick <= 1'b1;
        cyc(3);
        wd_tick <= 1'b0;
        wd_clr <= 1'b1;
        cyc(1);
        wd_clr <= 1'b0;
        wd_tick <= 1'b1;
        cyc(3);
        wd_tick <= 1'b0;
        cyc(3);
        `CHK(wd_seen - v, 32'h0)
        wd_tick <= 1'b1;
        cyc(1);
        wd_tick <= 1'b0;
        cyc(3);
        `CHK(wd_seen - v, 32'h1)
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cyc(4);
        reset_n <= 1'b1;
        hsel <= 1'b1;
        cyc(2);
        bus(1'h0, OPT, 32'h0);
        `CHK(rd, 32'hFF)
        bus(1'h0, CNT, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'h0, 32'h10, 32'h0);
        `CHK(rd, 32'h0)
        edge_case(32'h28, 32'h1);
        edge_case(32'h38, 32'h0);
        sleep <= 1'b1;
        pin <= 1'b1;
        cyc(10);
        pin <= 1'b0;
        cyc(10);
        bus(1'h0, CNT, 32'h0);
        `CHK(rd, 32'h1)
        sleep <= 1'b0;
        bus(1'h1, OPT, 32'h08);
        bus(1'h1, CNT, 32'h10);
        cyc(4);
        bus(1'h0, CNT, 32'h0);
        `CHK(rd, 32'h10)
        cyc(30);
        bus(1'h0, CNT, 32'h0);
        v = rd;
        cyc(30);
        bus(1'h0, CNT, 32'h0);
        `CHK(rd - v, 32'h8)
        bus(1'h1, CNT, 32'hFE);
        cyc(30);
        bus(1'h0, ICT, 32'h0);
        `CHK(rd, 32'h04)
        `CHK(irq, 1'b0)
        bus(1'h1, ENA, 32'h1);
        cyc(2);
        `CHK(irq, 1'b1)
        bus(1'h0, ICT, 32'h0);
        `CHK(rd, 32'h24)
        bus(1'h1, CLR, 32'h1);
        cyc(2);
        `CHK(irq, 1'b0)
        bus(1'h0, STS, 32'h0);
        `CHK(rd, 32'h0)
        for (int n = 0; n < 8; n++) begin
            bus(1'h1, OPT, 32'(n));
            bus(1'h1, CNT, 32'h0);
            cyc(12);
            bus(1'h0, CNT, 32'h0);
            v = rd;
            cyc(16 * (2 ** (n + 1)) - 2);
            bus(1'h0, CNT, 32'h0);
            `CHK(rd - v, 32'h4)
        end
        wd_case();
        results();
    end
endmodule
`default_nettype wire
